// ==== soec_pkg.sv ====
// Package with register map, field positions and reset values
package soec_pkg;
  localparam logic [7:0] ADDR_CHAN_MODE   = 8'hd8;
  localparam logic [7:0] ADDR_EVENT_MASK  = 8'hd9;
  localparam logic [7:0] ADDR_BOOL_CFG    = 8'hda;
  localparam logic [7:0] ADDR_BOOL_INV    = 8'hdb;
  localparam logic [7:0] ADDR_DEF_PTR     = 8'hdd;
  localparam logic [7:0] RST_CHAN_MODE    = 8'h07;
  localparam logic [7:0] RST_EVENT_MASK   = 8'h3f;
  localparam logic [7:0] RST_BOOL_CFG     = 8'h00;
  localparam logic [7:0] RST_BOOL_INV     = 8'h00;
  localparam logic [7:0] RST_DEF_PTR      = 8'h10;
  localparam logic [7:0] USE_CHAN_MODE    = 8'h0f;
  localparam logic [7:0] USE_EVENT_MASK   = 8'h3f;
  localparam logic [7:0] USE_BOOL_CFG     = 8'h0f;
  localparam logic [7:0] USE_BOOL_INV     = 8'h07;
  localparam int BIT_BLOCKER  = 3;
  localparam int BIT_AND_OR   = 3;
  localparam int EV_AUTOTUNE  = 5;
  localparam int EV_COMP      = 4;
  localparam int EV_BOOL      = 3;
  localparam int EV_NOISE     = 2;
  localparam int EV_TOUCH     = 1;
  localparam int EV_PROXIMITY_EVENT      = 0;
  localparam int NUM_CHAN     = 3;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_WINDOW = 3'b010,
    ST_CONV   = 3'b100
  } soec_state_t;
endpackage

// ==== soec_combine.sv ====
// Boolean combination of the channel outputs
`timescale 1ns/1ps
module soec_combine #(
  parameter int N = 3
) (
  input  wire logic [N-1:0] chan_in,
  input  wire logic [N-1:0] select,
  input  wire logic [N-1:0] invert,
  input  wire logic         use_or,
  output logic              bool_out
);
  logic [N-1:0] pol;
  logic [N-1:0] and_terms;
  logic [N-1:0] or_terms;
  // Invert first, then mask per channel
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      assign pol[i]       = chan_in[i] ^ invert[i];
      assign and_terms[i] = pol[i] | ~select[i];
      assign or_terms[i]  = pol[i] & select[i];
    end
  endgenerate
  // Pick operator; no selection forces inactive
  always_comb begin
    if (select == '0) begin
      bool_out = 1'b0;
    end else if (use_or) begin
      bool_out = |or_terms;
    end else begin
      bool_out = &and_terms;
    end
  end
endmodule

// ==== soec_events.sv ====
// Event detector gated by the event mask
`timescale 1ns/1ps
module soec_events (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] mask,
  input  wire logic       autotune_pass,
  input  wire logic       noise_seen,
  input  wire logic [2:0] comp_out,
  input  wire logic [2:0] touch_state,
  input  wire logic [2:0] proximity_event_state,
  input  wire logic       bool_out,
  output logic            event_hit
);
  import soec_pkg::*;
  logic [2:0] comp_q, next_comp_q;
  logic [2:0] touch_q, next_touch_q;
  logic [2:0] proximity_event_q, next_proximity_event_q;
  logic       bool_q, next_bool_q;
  // Remember last states for change detection
  always_comb begin
    next_comp_q  = comp_out;
    next_touch_q = touch_state;
    next_proximity_event_q  = proximity_event_state;
    next_bool_q  = bool_out;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_q  <= 3'h0;
      touch_q <= 3'h0;
      proximity_event_q  <= 3'h0;
      bool_q  <= 1'b0;
    end else begin
      comp_q  <= next_comp_q;
      touch_q <= next_touch_q;
      proximity_event_q  <= next_proximity_event_q;
      bool_q  <= next_bool_q;
    end
  end
  // Masked event sources
  assign event_hit =
      (mask[EV_AUTOTUNE] & autotune_pass)
    | (mask[EV_COMP] & (comp_out != comp_q))
    | (mask[EV_BOOL] & (bool_out != bool_q))
    | (mask[EV_NOISE] & noise_seen)
    | (mask[EV_TOUCH] & (touch_state != touch_q))
    | (mask[EV_PROXIMITY_EVENT] & (proximity_event_state != proximity_event_q));
endmodule

// ==== soec_top.sv ====
// Output and communication configuration bank with window control
`timescale 1ns/1ps
module soec_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  input  wire logic       i2c_start,
  input  wire logic       i2c_stop,
  input  wire logic       addr_write,
  input  wire logic [7:0] addr_value,
  input  wire logic       byte_read,
  output logic      [7:0] active_ptr,
  input  wire logic       event_mode,
  input  wire logic       cycle_done,
  input  wire logic       conv_done,
  output logic            conv_start,
  output logic            window_open,
  output logic            ready_n,
  input  wire logic [2:0] chan_raw,
  input  wire logic [2:0] chan_comp,
  input  wire logic [2:0] touch_state,
  input  wire logic [2:0] proximity_event_state,
  input  wire logic       autotune_pass,
  input  wire logic       noise_seen,
  output logic      [2:0] chan_out,
  output logic      [2:0] comp_mode,
  output logic            bool_out
);
  import soec_pkg::*;
  logic [7:0] chan_mode, next_chan_mode;
  logic [7:0] ev_mask, next_ev_mask;
  logic [7:0] bool_cfg, next_bool_cfg;
  logic [7:0] bool_inv, next_bool_inv;
  logic [7:0] def_ptr, next_def_ptr;
  logic [7:0] next_rdata;
  logic       next_hit;
  logic [7:0] next_ptr;
  soec_state_t state, next_state;
  logic       next_conv_start;
  logic [2:0] sel_out;
  logic [2:0] blocked;
  logic       bool_raw;
  logic       event_hit;
  logic       open_now;

  // Register writes, unused bits dropped
  always_comb begin
    next_chan_mode = chan_mode;
    next_ev_mask   = ev_mask;
    next_bool_cfg  = bool_cfg;
    next_bool_inv  = bool_inv;
    next_def_ptr   = def_ptr;
    if (reg_wr) begin
      if (reg_addr == ADDR_CHAN_MODE) begin
        next_chan_mode = reg_wdata & USE_CHAN_MODE;
      end else if (reg_addr == ADDR_EVENT_MASK) begin
        next_ev_mask = reg_wdata & USE_EVENT_MASK;
      end else if (reg_addr == ADDR_BOOL_CFG) begin
        next_bool_cfg = reg_wdata & USE_BOOL_CFG;
      end else if (reg_addr == ADDR_BOOL_INV) begin
        next_bool_inv = reg_wdata & USE_BOOL_INV;
      end else if (reg_addr == ADDR_DEF_PTR) begin
        next_def_ptr = reg_wdata;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_mode <= RST_CHAN_MODE;
      ev_mask   <= RST_EVENT_MASK;
      bool_cfg  <= RST_BOOL_CFG;
      bool_inv  <= RST_BOOL_INV;
      def_ptr   <= RST_DEF_PTR;
    end else begin
      chan_mode <= next_chan_mode;
      ev_mask   <= next_ev_mask;
      bool_cfg  <= next_bool_cfg;
      bool_inv  <= next_bool_inv;
      def_ptr   <= next_def_ptr;
    end
  end

  // Register read path, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (reg_rd) begin
      next_hit = 1'b1;
      if (reg_addr == ADDR_CHAN_MODE) begin
        next_rdata = chan_mode;
      end else if (reg_addr == ADDR_EVENT_MASK) begin
        next_rdata = ev_mask;
      end else if (reg_addr == ADDR_BOOL_CFG) begin
        next_rdata = bool_cfg;
      end else if (reg_addr == ADDR_BOOL_INV) begin
        next_rdata = bool_inv;
      end else if (reg_addr == ADDR_DEF_PTR) begin
        next_rdata = def_ptr;
      end else begin
        next_hit = 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_hit   <= next_hit;
    end
  end

  // Per channel mode, then blocker on channel 1
  genvar i;
  generate
    for (i = 0; i < NUM_CHAN; i++) begin : g_out
      assign sel_out[i] = chan_mode[i] ? chan_comp[i]
                                       : chan_raw[i];
      if (i == 1) begin : g_blk
        assign blocked[i] = sel_out[i];
      end else begin : g_blk
        assign blocked[i] = sel_out[i]
                          & ~(chan_mode[BIT_BLOCKER] & sel_out[1]);
      end
    end
  endgenerate
  assign comp_mode = chan_mode[2:0];

  soec_combine #(.N(NUM_CHAN)) u_comb (
    .chan_in  (blocked),
    .select   (bool_cfg[2:0]),
    .invert   (bool_inv[2:0]),
    .use_or   (bool_cfg[BIT_AND_OR]),
    .bool_out (bool_raw)
  );

  soec_events u_ev (
    .clk           (clk),
    .nrst          (nrst),
    .mask          (ev_mask),
    .autotune_pass (autotune_pass),
    .noise_seen    (noise_seen),
    .comp_out      (chan_comp),
    .touch_state   (touch_state),
    .proximity_event_state    (proximity_event_state),
    .bool_out      (bool_raw),
    .event_hit     (event_hit)
  );

  // Window opens per cycle, or only on events in event mode
  assign open_now = cycle_done & (~event_mode | event_hit);

  // Window and conversion sequencer with comms pointer
  always_comb begin
    next_state      = state;
    next_ptr        = active_ptr;
    next_conv_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (open_now) begin
          next_state = ST_WINDOW;
          next_ptr   = def_ptr;
        end else if (cycle_done) begin
          next_state      = ST_CONV;
          next_conv_start = 1'b1;
        end
      end
      ST_WINDOW: begin
        if (i2c_stop) begin
          next_state      = ST_CONV;
          next_conv_start = 1'b1;
        end else if (addr_write) begin
          next_ptr = addr_value;
        end else if (byte_read) begin
          next_ptr = active_ptr + 8'h01;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      active_ptr <= RST_DEF_PTR;
      conv_start <= 1'b0;
      chan_out   <= 3'h0;
      bool_out   <= 1'b0;
    end else begin
      state      <= next_state;
      active_ptr <= next_ptr;
      conv_start <= next_conv_start;
      chan_out   <= blocked;
      bool_out   <= bool_raw;
    end
  end
  assign window_open = (state == ST_WINDOW);
  assign ready_n     = ~(state == ST_WINDOW);

  // Checks next to the sequencer
  blk_sup_a: assert property (@(posedge clk) disable iff (!nrst)
    (chan_mode[BIT_BLOCKER] && sel_out[1]) |-> (blocked[0] == 1'b0
      && blocked[2] == 1'b0))
    else $error("blocker did not suppress");
  mode_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    !chan_mode[0] |-> sel_out[0] == chan_raw[0])
    else $error("direct mode wrong");
  ptr_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_IDLE && open_now) |=> active_ptr == $past(def_ptr))
    else $error("pointer not loaded");
  stop_conv_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_WINDOW && i2c_stop) |=> conv_start && state == ST_CONV)
    else $error("stop did not start conversion");
  rdy_low_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_CONV && !conv_done) |=> ready_n)
    else $error("ready released early");
  ev_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_IDLE && cycle_done && event_mode && !event_hit)
      |=> state != ST_WINDOW)
    else $error("window without event");
  bool_none_a: assert property (@(posedge clk) disable iff (!nrst)
    bool_cfg[2:0] == 3'h0 |-> !bool_raw)
    else $error("boolean active with no selection");
  unused_a: assert property (@(posedge clk) disable iff (!nrst)
    bool_inv[7:3] == 5'h00 && ev_mask[7:6] == 2'h0
      && chan_mode[7:4] == 4'h0 && bool_cfg[7:4] == 4'h0)
    else $error("unused bit stored");
  win_c: cover property (@(posedge clk) disable iff (!nrst)
    state == ST_IDLE ##1 state == ST_WINDOW ##[1:20] state == ST_CONV);
  blk_c: cover property (@(posedge clk) disable iff (!nrst)
    chan_mode[BIT_BLOCKER] && sel_out[1] && sel_out[0]);
  ev_c: cover property (@(posedge clk) disable iff (!nrst)
    event_mode && cycle_done && event_hit);
endmodule

// ==== soec_host.sv ====
// Host model: transfers chained in one window, then STOP
`timescale 1ns/1ps
module soec_host (
  input  wire logic       clk,
  output logic            i2c_start,
  output logic            i2c_stop,
  output logic            addr_write,
  output logic      [7:0] addr_value,
  output logic            byte_read
);
  // Idle host from time zero
  initial begin
    i2c_start  = 1'b0;
    i2c_stop   = 1'b0;
    addr_write = 1'b0;
    addr_value = 8'h00;
    byte_read  = 1'b0;
  end
  // Pointer write behind a repeated START keeps the window open
  task automatic point(input logic [7:0] a);
    @(posedge clk);
    i2c_start  <= 1'b1;
    addr_write <= 1'b1;
    addr_value <= a;
    @(posedge clk);
    i2c_start  <= 1'b0;
    addr_write <= 1'b0;
    addr_value <= ~a;  // No stale value once released
  endtask
  // Byte reads, gap idle cycles after each for a slow host
  task automatic reads(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      byte_read <= 1'b1;
      @(posedge clk);
      byte_read <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
  // STOP only once all transfers of the window are done
  task automatic stop();
    @(posedge clk);
    i2c_stop <= 1'b1;
    @(posedge clk);
    i2c_stop <= 1'b0;
  endtask
endmodule

// ==== sensor_output_event_config_tb.sv ====
// Self-checking bench for the output and event configuration bank
`timescale 1ns/1ps
module sensor_output_event_config_tb;
  import soec_pkg::*;
  typedef struct {
    logic [7:0] addr, rst, wdata, rdata;
  } soec_reg_row_t;
  typedef struct {
    logic [7:0] mode, cfg, inv;
    logic [2:0] raw, comp, out;
    logic       bo;
  } soec_mix_row_t;
  logic       clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       event_mode = 1'b0, cycle_done = 1'b0, conv_done = 1'b0;
  logic       autotune_pass = 1'b0, noise_seen = 1'b0;
  logic       i2c_start, i2c_stop, addr_write, byte_read, reg_hit;
  logic       conv_start, window_open, ready_n, bool_out;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, addr_value, active_ptr;
  logic [2:0] chan_raw = 3'h0, chan_comp = 3'h0, touch_state = 3'h0;
  logic [2:0] proximity_event_state = 3'h0, chan_out, comp_mode;
  int         err_count = 0, check_count = 0;
  soec_reg_row_t regs[6] = '{
    '{8'hd8, 8'h07, 8'hff, 8'h0f}, '{8'hd9, 8'h3f, 8'hff, 8'h3f},
    '{8'hda, 8'h00, 8'hff, 8'h0f}, '{8'hdb, 8'h00, 8'hff, 8'h07},
    '{8'hdd, 8'h10, 8'h31, 8'h31}, '{8'hdc, 8'h00, 8'h55, 8'h00}};
  soec_mix_row_t mix[9] = '{
    '{8'h07, 8'h07, 8'h00, 3'h0, 3'h7, 3'h7, 1'b1},
    '{8'h00, 8'h07, 8'h00, 3'h5, 3'h7, 3'h5, 1'b0},
    '{8'h00, 8'h0f, 8'h00, 3'h5, 3'h7, 3'h5, 1'b1},
    '{8'h08, 8'h0f, 8'h00, 3'h7, 3'h0, 3'h2, 1'b1},
    '{8'h08, 8'h0d, 8'h00, 3'h7, 3'h0, 3'h2, 1'b0},
    '{8'h00, 8'h05, 8'h04, 3'h1, 3'h0, 3'h1, 1'b1},
    '{8'h00, 8'h08, 8'h07, 3'h0, 3'h0, 3'h0, 1'b0},
    '{8'h02, 8'h02, 8'h00, 3'h5, 3'h0, 3'h5, 1'b0},
    '{8'h08, 8'h0f, 8'h00, 3'h5, 3'h7, 3'h5, 1'b1}};
  int         evb[6] = '{5, 4, 3, 2, 1, 0};

  soec_top uut (.*);
  soec_host host (.*);

  // Clock generation
  always #2.5 clk = ~clk;

  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write, one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Register read, returns where the answer stands
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  // One finished sensing cycle
  task automatic cyc();
    @(posedge clk);
    cycle_done <= 1'b1;
    @(posedge clk);
    cycle_done <= 1'b0;
    #1;
  endtask
  // Conversion runs with ready_n high, then completes
  task automatic conv();
    repeat (3) begin
      @(posedge clk);
      #1 chk(8'(ready_n), 8'h01);
    end
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask
  // One event source fired with a sensing cycle under mask m
  task automatic ev(input int b, input logic [7:0] m, input logic hit);
    wr(8'hd9, m);
    @(posedge clk);
    cycle_done <= 1'b1;
    case (b)
      5: autotune_pass <= 1'b1;
      4: chan_comp <= ~chan_comp;
      3: chan_raw[2] <= ~chan_raw[2];  // Flips the combined output
      2: noise_seen <= 1'b1;
      1: touch_state <= ~touch_state;
      default: proximity_event_state <= ~proximity_event_state;
    endcase
    @(posedge clk);
    cycle_done    <= 1'b0;
    autotune_pass <= 1'b0;
    noise_seen    <= 1'b0;
    #1 chk(8'(window_open), 8'(hit));
    chk(8'(conv_start), 8'(!hit));
    if (hit) begin
      host.stop();
      #1 chk(8'(conv_start), 8'h01);
    end
    conv();
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(active_ptr, 8'h10);
    chk(8'(ready_n), 8'h01);
    foreach (regs[i]) begin
      rd(regs[i].addr);
      chk(reg_rdata, regs[i].rst);
      chk(8'(reg_hit), 8'(regs[i].addr != 8'hdc));
    end
    foreach (regs[i]) begin
      wr(regs[i].addr, regs[i].wdata);
      rd(regs[i].addr);
      chk(reg_rdata, regs[i].rdata);
    end
    foreach (mix[i]) begin
      wr(8'hd8, mix[i].mode);
      wr(8'hda, mix[i].cfg);
      wr(8'hdb, mix[i].inv);
      @(posedge clk);
      chan_raw  <= mix[i].raw;
      chan_comp <= mix[i].comp;
      repeat (3) @(posedge clk);
      #1 chk(8'(chan_out), 8'(mix[i].out));
      chk(8'(comp_mode), 8'(mix[i].mode[2:0]));
      chk(8'(bool_out), 8'(mix[i].bo));
    end
    // Continuous mode window with prompt and slow host
    cyc();
    chk(8'(window_open), 8'h01);
    chk(8'(ready_n), 8'h00);
    chk(active_ptr, 8'h31);
    host.reads(2, 0);
    #1 chk(active_ptr, 8'h33);
    host.point(8'hd8);
    #1 chk(active_ptr, 8'hd8);
    host.reads(1, 2);
    #1 chk(active_ptr, 8'hd9);
    host.stop();
    #1 chk(8'(conv_start), 8'h01);
    chk(8'(window_open), 8'h00);
    conv();
    cyc();
    chk(active_ptr, 8'h31);
    host.stop();
    conv();
    // Settling run of conversions after setup, pointer reloaded each window
    repeat (24) begin
      cyc();
      chk(active_ptr, 8'h31);
      host.stop();
      conv();
    end
    // Event mode, each source masked in and masked out
    event_mode <= 1'b1;
    // Channel 2 direct and alone in the combination, so raw flips move it
    wr(8'hd8, 8'h03);
    wr(8'hda, 8'h04);
    foreach (evb[i]) begin
      ev(evb[i], 8'h01 << evb[i], 1'b1);
      ev(evb[i], 8'h3f ^ (8'h01 << evb[i]), 1'b0);
    end
    // Second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(8'hdd);
    chk(reg_rdata, 8'h10);
    chk(active_ptr, 8'h10);
    conclude();
  end
endmodule
